/* File: ee_pkg.sv */
// constants, state codes and carrier types for the two-wire eeprom slave
`default_nettype none
package ee_pkg;

  // array organisation
  localparam int unsigned ADDR_W       = 9;
  localparam int unsigned MEM_BYTES    = 512;
  localparam int unsigned PAGE_BYTES   = 16;
  localparam int unsigned PAGE_W       = 4;
  localparam int unsigned PROT_BIT     = 8;

  // device select byte
  localparam logic [3:0]  CTRL_CODE    = 4'ha;
  localparam int unsigned SEL_CODE_LSB = 4;
  localparam int unsigned SEL_STRAP_HI = 3;
  localparam int unsigned SEL_STRAP_LO = 2;
  localparam int unsigned SEL_PAGE_BIT = 1;
  localparam int unsigned SEL_RW_BIT   = 0;

  // serial framing
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  // write buffer
  localparam int unsigned FIFO_DEPTH   = 16;

  // self-timed programming cycle, longest time rounds down
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned PROG_TIME_NS  = 5000000;
  localparam int unsigned PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W       = 20;

  // input synchroniser lanes
  localparam int unsigned SYNC_W        = 5;
  localparam int unsigned LANE_SCL      = 0;
  localparam int unsigned LANE_SDA      = 1;
  localparam int unsigned LANE_STRAP_LO = 2;
  localparam int unsigned LANE_STRAP_HI = 3;
  localparam int unsigned LANE_WP       = 4;

  // values after reset
  localparam logic [ADDR_W-1:0] ADDR_RST  = 9'h000;
  localparam logic [7:0]        BYTE_RST  = 8'h00;
  localparam logic [3:0]        CNT_RST   = 4'h0;
  localparam logic [SYNC_W-1:0] SYNC_RST  = 5'h03;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_WORD = 3'b011,
    ST_WR   = 3'b010,
    ST_RD   = 3'b110,
    ST_WAIT = 3'b111
  } ee_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } ee_wr_entry_t;

  localparam int unsigned ENTRY_W = ADDR_W + 8;

endpackage
`default_nettype wire

/* File: ee_eeprom.sv */
// two-wire serial eeprom slave with write buffer and self-timed programming
`default_nettype none

module ee_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W:0]   wr_ptr_reg;
  logic [PTR_W:0]   rd_ptr_reg;
  logic             full;
  logic             empty;

  // extra pointer bit tells full from empty
  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign full      = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
                     (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = store[rd_ptr_reg[PTR_W-1:0]];

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_reg <= '0;
    end
    else if (in_valid && !full)
    begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_ptr_reg <= '0;
    end
    else if (out_ready && !empty)
    begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (in_valid && !full)
    begin
      store[wr_ptr_reg[PTR_W-1:0]] <= in_data;
    end
  end

endmodule

// Overview of operation
// [RQ1] sample sda on rising serial clock edges
// [RQ2] change driven sda only after falling edges
// [RQ3] open drain: pull low or release only
// [RQ4] master keeps scl high while idle
// [RQ5] protect strap high blocks upper-half writes
// [RQ6] protect strap low allows all writes
// [RQ7] answer only when select matches strap levels
// [RQ8] undriven straps and protect read as low
// [RQ9] 512 bytes with nine-bit byte address
// [RQ10] page write up to 16 bytes, partial ok
// [RQ11] self-timed programming within 5 ms
// [RQ12] work at 100 kHz and 400 kHz clocks
// [RQ13] random, current and sequential reads
// [RQ14] ignore bus until reset released, then standby
// [RQ15] master waits power-up delay before commands
// [RQ16] no select acknowledge while programming
module ee_eeprom #(
  parameter int unsigned PROG_CYCLES = ee_pkg::PROG_CYCLES
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // two-wire bus
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // straps
  input  wire logic addr_strap_low,
  input  wire logic addr_strap_high,
  input  wire logic wp
);

  logic [ee_pkg::SYNC_W-1:0]  meta_reg;
  logic [ee_pkg::SYNC_W-1:0]  sync_reg;
  logic                       scl_prev_reg;
  logic                       sda_prev_reg;
  logic                       scl_s;
  logic                       sda_s;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       start_det;
  logic                       stop_det;

  ee_pkg::ee_state_t          state_reg;
  logic [3:0]                 bit_cnt_reg;
  logic [7:0]                 shift_reg;
  logic [7:0]                 tx_reg;
  logic                       ack_phase_reg;
  logic                       rw_reg;
  logic                       page_hi_reg;
  logic                       master_nack_reg;
  logic [ee_pkg::ADDR_W-1:0]  addr_reg;
  logic                       sda_oe_reg;

  logic [7:0]                 mem [ee_pkg::MEM_BYTES];
  logic [7:0]                 rd_byte;
  logic                       sel_match;
  logic                       byte_done;
  logic                       protected_addr;

  logic                       busy_reg;
  logic [ee_pkg::TIMER_W-1:0] timer_reg;
  logic                       prog_go;

  ee_pkg::ee_wr_entry_t       push_entry;
  ee_pkg::ee_wr_entry_t       pop_entry;
  logic [ee_pkg::ENTRY_W-1:0] pop_bits;
  logic                       push_valid;
  logic                       push_ready;
  logic                       pop_valid;
  logic                       pop_ready;

  // two flip-flops on every pin before any logic looks at it
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_reg <= ee_pkg::SYNC_RST;
      sync_reg <= ee_pkg::SYNC_RST;
    end
    else
    begin
      meta_reg <= {wp, addr_strap_high, addr_strap_low, sda_i, scl_i};
      sync_reg <= meta_reg;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // bus idle means scl high, so reset values of high avoid a false edge
  assign scl_s     = sync_reg[ee_pkg::LANE_SCL]; // RQ4
  assign sda_s     = sync_reg[ee_pkg::LANE_SDA];
  assign scl_rise  = scl_s && !scl_prev_reg; // RQ12
  assign scl_fall  = !scl_s && scl_prev_reg;
  assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_det  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  // the pad pull-down makes a floating strap a plain low here
  assign sel_match = (shift_reg[7:ee_pkg::SEL_CODE_LSB] == ee_pkg::CTRL_CODE) &&
                     (shift_reg[ee_pkg::SEL_STRAP_HI] == sync_reg[ee_pkg::LANE_STRAP_HI]) && // RQ8
                     (shift_reg[ee_pkg::SEL_STRAP_LO] == sync_reg[ee_pkg::LANE_STRAP_LO]) && // RQ7
                     !busy_reg; // RQ16
  assign byte_done = scl_fall && !ack_phase_reg && (bit_cnt_reg == ee_pkg::BITS_PER_BYTE);
  assign protected_addr = sync_reg[ee_pkg::LANE_WP] && addr_reg[ee_pkg::PROT_BIT]; // RQ5 RQ6
  assign rd_byte   = mem[addr_reg];

  // data bytes enter the buffer only when not protected
  assign push_entry = '{addr: addr_reg, data: shift_reg};
  assign push_valid = byte_done && (state_reg == ee_pkg::ST_WR) && !protected_addr; // RQ5
  assign prog_go    = stop_det && pop_valid && !busy_reg;

  // open drain: the pin output is always low, only the enable moves
  assign sda_o  = 1'b0; // RQ3
  assign sda_oe = sda_oe_reg; // RQ3

  // serial protocol
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg       <= ee_pkg::ST_IDLE; // RQ14
      bit_cnt_reg     <= ee_pkg::CNT_RST;
      shift_reg       <= ee_pkg::BYTE_RST;
      tx_reg          <= ee_pkg::BYTE_RST;
      ack_phase_reg   <= 1'b0;
      rw_reg          <= 1'b0;
      page_hi_reg     <= 1'b0;
      master_nack_reg <= 1'b0;
      addr_reg        <= ee_pkg::ADDR_RST;
      sda_oe_reg      <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg     <= ee_pkg::ST_DEV;
      bit_cnt_reg   <= ee_pkg::CNT_RST;
      ack_phase_reg <= 1'b0;
      sda_oe_reg    <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg     <= ee_pkg::ST_IDLE;
      bit_cnt_reg   <= ee_pkg::CNT_RST;
      ack_phase_reg <= 1'b0;
      sda_oe_reg    <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (ack_phase_reg)
      begin
        master_nack_reg <= sda_s; // RQ1
      end
      else if (state_reg != ee_pkg::ST_IDLE && state_reg != ee_pkg::ST_WAIT &&
               bit_cnt_reg != ee_pkg::BITS_PER_BYTE)
      begin
        shift_reg   <= {shift_reg[6:0], sda_s}; // RQ1
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
    else if (byte_done)
    begin
      ack_phase_reg <= 1'b1;
      unique case (state_reg)
        ee_pkg::ST_DEV:
        begin
          rw_reg      <= shift_reg[ee_pkg::SEL_RW_BIT];
          page_hi_reg <= shift_reg[ee_pkg::SEL_PAGE_BIT];
          sda_oe_reg  <= sel_match; // RQ2 RQ7 RQ16
          if (!sel_match)
          begin
            state_reg <= ee_pkg::ST_WAIT;
          end
        end
        ee_pkg::ST_WORD:
        begin
          addr_reg   <= {page_hi_reg, shift_reg}; // RQ9
          sda_oe_reg <= 1'b1;
        end
        ee_pkg::ST_WR:
        begin
          // a seventeenth byte would overrun the page, so it is refused
          sda_oe_reg <= push_ready; // RQ10
          addr_reg   <= {addr_reg[ee_pkg::ADDR_W-1:ee_pkg::PAGE_W],
                         addr_reg[ee_pkg::PAGE_W-1:0] + 4'h1}; // RQ10
        end
        ee_pkg::ST_RD:
        begin
          sda_oe_reg <= 1'b0; // RQ2
        end
        default:
        begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
    else if (scl_fall && ack_phase_reg)
    begin
      ack_phase_reg <= 1'b0;
      bit_cnt_reg   <= ee_pkg::CNT_RST;
      sda_oe_reg    <= 1'b0;
      unique case (state_reg)
        ee_pkg::ST_DEV:
        begin
          if (rw_reg)
          begin
            state_reg  <= ee_pkg::ST_RD; // RQ13
            tx_reg     <= {rd_byte[6:0], 1'b0};
            sda_oe_reg <= !rd_byte[7]; // RQ2
            addr_reg   <= addr_reg + 9'h001; // RQ13
          end
          else
          begin
            state_reg <= ee_pkg::ST_WORD;
          end
        end
        ee_pkg::ST_WORD:
        begin
          state_reg <= ee_pkg::ST_WR;
        end
        ee_pkg::ST_RD:
        begin
          if (master_nack_reg)
          begin
            state_reg <= ee_pkg::ST_WAIT;
          end
          else
          begin
            tx_reg     <= {rd_byte[6:0], 1'b0};
            sda_oe_reg <= !rd_byte[7]; // RQ2
            addr_reg   <= addr_reg + 9'h001; // RQ13
          end
        end
        default:
        begin
          state_reg <= state_reg;
        end
      endcase
    end
    else if (scl_fall && state_reg == ee_pkg::ST_RD)
    begin
      tx_reg     <= {tx_reg[6:0], 1'b0};
      sda_oe_reg <= !tx_reg[7]; // RQ2
    end
  end

  ee_fifo #(
    .WIDTH (ee_pkg::ENTRY_W),
    .DEPTH (ee_pkg::FIFO_DEPTH)
  ) u_wr_buf (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_entry),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_bits)
  );

  // the buffer drains only while programming, so a page really fills first
  assign pop_entry = pop_bits;
  assign pop_ready = busy_reg;

  // self-timed programming cycle, no bus clocks needed
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_reg  <= 1'b0;
      timer_reg <= '0;
    end
    else if (prog_go)
    begin
      busy_reg  <= 1'b1; // RQ11
      timer_reg <= ee_pkg::TIMER_W'(PROG_CYCLES - 1);
    end
    else if (busy_reg)
    begin
      if (timer_reg != '0)
      begin
        timer_reg <= timer_reg - 1'b1; // RQ11
      end
      else if (!pop_valid)
      begin
        busy_reg <= 1'b0;
      end
    end
  end

  // array contents survive reset
  always_ff @(posedge clock)
  begin
    if (pop_valid && pop_ready)
    begin
      mem[pop_entry.addr] <= pop_entry.data; // RQ6 RQ9 RQ10
    end
  end

endmodule
`default_nettype wire

/* File: ee_eeprom_chk.sv */
// assertion checker for the two-wire eeprom slave pins
`default_nettype none
module ee_eeprom_chk #(
  parameter int unsigned PROG_CYCLES = 200
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bus and straps
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic addr_strap_low,
  input wire logic addr_strap_high,
  input wire logic wp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        scl_q, sda_q, wr_seen;
  logic [4:0]  bit_cnt;
  logic [7:0]  sh, sel_q;
  int unsigned quiet;
  wire logic   start_c = scl_i & scl_q & sda_q & ~sda_i;
  wire logic   stop_c  = scl_i & scl_q & ~sda_q & sda_i;
  wire logic   rise_c  = scl_i & ~scl_q;
  wire logic   sel_c   = rise_c & (bit_cnt == 5'h08);
  // bus decode mirrors what the master sent since the last start
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      {scl_q, sda_q} <= 2'h3;
      bit_cnt <= 5'h00;
      sh <= 8'h00;
      sel_q <= 8'h00;
    end
    else
    begin
      {scl_q, sda_q} <= {scl_i, sda_i};
      if (start_c)
        bit_cnt <= 5'h00;
      else if (rise_c && bit_cnt != 5'h1f)
        bit_cnt <= bit_cnt + 5'h01;
      if (rise_c)
        sh <= {sh[6:0], sda_i};
      if (sel_c)
        sel_q <= sh;
    end
  // protected bytes start no programming, so they open no busy window
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      wr_seen <= 1'b0;
      quiet <= PROG_CYCLES;
    end
    else
    begin
      if (start_c)
        wr_seen <= 1'b0;
      else if (rise_c && bit_cnt == 5'h1a && sda_oe && !sel_q[0] && !(wp && sel_q[1]))
        wr_seen <= 1'b1;
      if (stop_c && wr_seen)
        quiet <= 0;
      else if (quiet < PROG_CYCLES)
        quiet <= quiet + 1;
    end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_drain; sda_o == 1'b0; endproperty
  property p_oe_edge; $changed(sda_oe) |-> !scl_i && !$past(scl_i); endproperty
  property p_oe_hold; $rose(scl_i) |-> $stable(sda_oe)[*6]; endproperty
  property p_por; $rose(rstn) |-> !sda_oe[*4]; endproperty
  property p_code; sel_c && sda_oe |-> sh[7:4] == ee_pkg::CTRL_CODE; endproperty
  property p_strap; sel_c && sda_oe |-> sh[3:2] == {addr_strap_high, addr_strap_low}; endproperty
  property p_busy; sel_c && quiet < PROG_CYCLES |-> !sda_oe; endproperty
  property p_stop_rel; stop_c |=> !sda_oe[*8]; endproperty
  a_drain: assert property (p_drain)
    else $error("data pin driven high");
  a_oe_edge: assert property (p_oe_edge)
    else $error("data changed outside clock low");
  a_oe_hold: assert property (p_oe_hold)
    else $error("data moved while clock high");
  a_por: assert property (p_por)
    else $error("bus driven right after reset");
  a_code: assert property (p_code)
    else $error("select acked with wrong code");
  a_strap: assert property (p_strap)
    else $error("select acked with strap mismatch");
  a_busy: assert property (p_busy)
    else $error("select acked while programming");
  a_stop_rel: assert property (p_stop_rel)
    else $error("bus driven after stop");
  c_sel_ack: cover property (sel_c && sda_oe);
  c_busy: cover property (sel_c && quiet < PROG_CYCLES);
  c_stop: cover property (stop_c && wr_seen);
endmodule
bind ee_eeprom ee_eeprom_chk #(.PROG_CYCLES(PROG_CYCLES)) u_ee_eeprom_chk (
  .clock(clock), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .addr_strap_low(addr_strap_low),
  .addr_strap_high(addr_strap_high), .wp(wp));
`default_nettype wire

/* File: ee_master.sv */
// bus master model driving the serial clock and sharing the data wire
`default_nettype none
module ee_master (
  // clock
  input  wire logic clock,
  // bus
  input  wire logic sda_oe,
  output var  logic scl_i,
  output logic      sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_low;
  // pull-up: the wire is high unless a party pulls it
  assign sda_i = ~(m_low | sda_oe);
  initial
  begin
    scl_i = 1'b1;
    m_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // 16 clocks a bit gives the 80 ns serial period
  task automatic bit_io(input logic b, output logic s);
    tick(4);
    m_low <= ~b;
    tick(4);
    scl_i <= 1'b1;
    tick(4);
    s = sda_i;
    tick(4);
    scl_i <= 1'b0;
  endtask
  task automatic start;
    tick(4);
    m_low <= 1'b0;
    tick(4);
    scl_i <= 1'b1;
    tick(4);
    m_low <= 1'b1;
    tick(4);
    scl_i <= 1'b0;
  endtask
  // clock is left high afterwards: idle bus
  task automatic stop;
    tick(4);
    m_low <= 1'b1;
    tick(4);
    scl_i <= 1'b1;
    tick(4);
    m_low <= 1'b0;
    tick(4);
  endtask
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic byte_r(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule
`default_nettype wire

/* File: ee_eeprom_tb_top.sv */
// self-checking bench for the two-wire eeprom slave
`default_nettype none
module ee_eeprom_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PROG = 200;
  typedef struct packed {logic [8:0] a; logic [7:0] d; logic w; logic [7:0] e;} ee_row_t;
  logic       clock, rstn, a_hi, a_lo, wp, ack;
  wire logic  scl, sda, sda_o, sda_oe;
  logic [7:0] rd;
  logic [7:0] exp_q[$];
  int         bad_count, n_compared;
  ee_row_t    rows[6] = '{'{9'h000, 8'h5a, 1'b0, 8'h5a}, '{9'h0ff, 8'ha5, 1'b1, 8'ha5},
    '{9'h100, 8'h3c, 1'b0, 8'h3c}, '{9'h100, 8'hc3, 1'b1, 8'h3c},
    '{9'h1ff, 8'h7e, 1'b0, 8'h7e}, '{9'h1ff, 8'h11, 1'b1, 8'h7e}};
  ee_eeprom #(.PROG_CYCLES(PROG)) u_ee_eeprom (.clock(clock), .rstn(rstn), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_low(a_lo),
    .addr_strap_high(a_hi), .wp(wp));
  ee_master u_ee_master (.clock(clock), .sda_oe(sda_oe), .scl_i(scl), .sda_i(sda));
  always #2.5 clock = ~clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [7:0] sel(input logic [1:0] a, input logic p, input logic r);
    return {ee_pkg::CTRL_CODE, a, p, r};
  endfunction
  task automatic wr(input logic [8:0] a, input logic [7:0] d0, input int n);
    u_ee_master.start();
    u_ee_master.byte_w(sel({a_hi, a_lo}, a[8], 1'b0), ack);
    u_ee_master.byte_w(a[7:0], ack);
    for (int i = 0; i < n; i++)
    begin
      u_ee_master.byte_w(d0 + 8'(i), ack);
      check({7'h00, ack}, {7'h00, i < 16});
    end
    u_ee_master.stop();
  endtask
  // polls of 176 clocks each; the bound follows from the programming length
  task automatic poll(input logic busy);
    int k;
    k = 0;
    ack = 1'b0;
    while (!ack && k < PROG / 100 + 2)
    begin
      u_ee_master.start();
      u_ee_master.byte_w(sel({a_hi, a_lo}, 1'b0, 1'b0), ack);
      u_ee_master.stop();
      if (k == 0)
        check({7'h00, ack}, {7'h00, !busy});
      k++;
    end
    check({7'h00, ack}, 8'h01);
    if (ack !== 1'b1)
      stop_test();
  endtask
  task automatic rd_seq(input logic [8:0] a, input int n);
    u_ee_master.start();
    u_ee_master.byte_w(sel({a_hi, a_lo}, a[8], 1'b0), ack);
    u_ee_master.byte_w(a[7:0], ack);
    u_ee_master.start();
    u_ee_master.byte_w(sel({a_hi, a_lo}, a[8], 1'b1), ack);
    for (int i = 0; i < n; i++)
    begin
      u_ee_master.byte_r(i == n - 1, rd);
      check(rd, exp_q[i]);
    end
    u_ee_master.stop();
  endtask
  initial
  begin
    clock = 1'b0;
    rstn = 1'b0;
    {a_hi, a_lo, wp} = 3'h0;
    bad_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    u_ee_master.tick(20);
    check({7'h00, sda_oe}, 8'h00);
    foreach (rows[i])
    begin
      wp <= rows[i].w;
      u_ee_master.tick(4);
      wr(rows[i].a, rows[i].d, 1);
      poll(!(rows[i].w && rows[i].a[8]));
      exp_q = '{rows[i].e};
      rd_seq(rows[i].a, 1);
      $display("row %0d done", i);
    end
    wp <= 1'b0;
    // current read: the pointer left the top byte and wrapped to zero
    u_ee_master.start();
    u_ee_master.byte_w(sel({a_hi, a_lo}, 1'b0, 1'b1), ack);
    u_ee_master.byte_r(1'b1, rd);
    u_ee_master.stop();
    check(rd, rows[0].e);
    // 17 bytes into a page starting mid-page: wrap inside page, last one refused
    wr(9'h02a, 8'h40, 17);
    poll(1'b1);
    exp_q = {};
    for (int j = 0; j < 16; j++)
      exp_q.push_back(8'h40 + 8'((j + 6) % 16));
    rd_seq(9'h020, 16);
    exp_q = '{8'h7e, 8'h5a};
    rd_seq(9'h1ff, 2);
    $display("page and wrap test done");
    for (int s = 0; s < 4; s++)
    begin
      {a_hi, a_lo} <= 2'(s);
      u_ee_master.tick(4);
      for (int t = 0; t < 4; t++)
      begin
        u_ee_master.start();
        u_ee_master.byte_w(sel(2'(t), 1'b0, 1'b0), ack);
        u_ee_master.stop();
        check({7'h00, ack}, {7'h00, s == t});
      end
    end
    $display("strap test done");
    rstn <= 1'b0;
    u_ee_master.start();
    u_ee_master.byte_w(sel({a_hi, a_lo}, 1'b0, 1'b0), ack);
    u_ee_master.stop();
    check({7'h00, ack}, 8'h00);
    rstn <= 1'b1;
    u_ee_master.tick(20);
    poll(1'b0);
    $display("reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
